// *** rtl/frs_cmd_decoder.sv ***
// Purpose: Decoder for the register and setting commands of a serial flash.
// Assumes: Serial mode 0; the link clock is far slower than mclk and is oversampled.
// Notes:   Commands without read data act at chip select release.
//
// Operation
// - Opcode 04h in either mode clears the write enable latch.
// - Opcode 05h in either mode streams the status register out.
// - Opcode 15h in either mode streams the configuration register out.
// - Opcode 01h takes one or two bytes: status, then configuration.
// - Opcode 68h in either mode selects individual block protection.
// - 35h enters four-wire mode from single-wire; F5h leaves it.
// - Opcode B0h in either mode suspends program or erase.
// - Opcode 30h in either mode resumes program or erase.
// - Opcode B9h in either mode enters deep power-down.
// - Opcode ABh in either mode leaves deep power-down.
// - Opcode C0h in either mode sets the wrapped read burst length.
// - Single-wire opcode 16h returns fast-boot bytes until chip select rises.
// - Single-wire 17h with four bytes writes fast-boot; 18h erases it.
// - Four-wire mode uses four lines and leaves the quad enable bit alone.
`default_nettype none

module frs_cmd_decoder (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              cs_n,
    input  wire logic              sclk,
    input  wire logic [3:0]        io_in,
    output var  frs_pkg::frs_pin_t io_drive,
    output var  frs_pkg::frs_settings_t settings,
    output logic                   suspend_req,
    output logic                   resume_req
);
    import frs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic       sclk_s1, sclk_s2, sclk_d;
    logic       cs_s1, cs_s2, cs_d;
    logic [3:0] io_s1, io_s2;
    frs_state_t state;
    logic [7:0] opcode;
    logic [7:0] rx;
    logic [7:0] out_sh;
    logic [2:0] bit_cnt;
    logic [2:0] out_cnt;
    logic [2:0] n_bytes;
    logic [1:0] out_idx;
    logic [31:0] dbuf;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic opcode_valid(input logic [7:0] op, input logic q, input logic dpd);
        logic ok;
        case (op)
            OP_ENTER_FOUR:                              ok = !q;
            OP_EXIT_FOUR:                               ok = q;
            OP_READ_BOOT, OP_WRITE_BOOT, OP_ERASE_BOOT: ok = !q;
            OP_SET_LATCH, OP_CLEAR_LATCH, OP_READ_STATUS, OP_READ_CONFIG, OP_WRITE_STATUS,
            OP_PROTECT_SEL, OP_SUSPEND, OP_RESUME, OP_PD_ENTER, OP_PD_RELEASE,
            OP_SET_WRAP:                                ok = 1'b1;
            default:                                    ok = 1'b0;
        endcase
        // While powered down only the release command is heard.
        opcode_valid = dpd ? (op == OP_PD_RELEASE) : ok;
    endfunction : opcode_valid

    function automatic logic is_read(input logic [7:0] op);
        is_read = (op == OP_READ_STATUS) || (op == OP_READ_CONFIG) || (op == OP_READ_BOOT);
    endfunction : is_read

    function automatic logic count_ok(input logic [7:0] op, input logic [2:0] n);
        case (op)
            OP_WRITE_STATUS: count_ok = (n == 3'h1) || (n == 3'h2);
            OP_SET_WRAP:     count_ok = (n == 3'h1);
            OP_WRITE_BOOT:   count_ok = (n == BOOT_BYTES);
            default:         count_ok = (n == 3'h0);
        endcase
    endfunction : count_ok

    function automatic logic [7:0] read_byte(input logic [7:0] op, input logic [1:0] idx,
                                             input logic [7:0] sts, input frs_settings_t s);
        logic [7:0] b;
        case (idx)
            2'h0:    b = s.boot[31:24];
            2'h1:    b = s.boot[23:16];
            2'h2:    b = s.boot[15:8];
            default: b = s.boot[7:0];
        endcase
        case (op)
            OP_READ_STATUS: read_byte = sts;
            OP_READ_CONFIG: read_byte = s.config_reg;
            default:        read_byte = b;
        endcase
    endfunction : read_byte

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_s1 <= 1'h0;
            sclk_s2 <= 1'h0;
            sclk_d  <= 1'h0;
            cs_s1   <= 1'h1;
            cs_s2   <= 1'h1;
            cs_d    <= 1'h1;
            io_s1   <= 4'h0;
            io_s2   <= 4'h0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
            cs_s1   <= cs_n;
            cs_s2   <= cs_s1;
            cs_d    <= cs_s2;
            io_s1   <= io_in;
            io_s2   <= io_s1;
        end
    end

    // ----------------------------------------
    // Shift-in and decode
    // ----------------------------------------
    wire logic       quad          = settings.four_wire;
    wire logic       active        = ~cs_s2;
    wire logic       sclk_rise     = sclk_s2 & ~sclk_d;
    wire logic       sclk_fall     = ~sclk_s2 & sclk_d;
    wire logic       cs_rise       = cs_s2 & ~cs_d;
    wire logic [2:0] step          = quad ? 3'h4 : 3'h1;
    wire logic [7:0] next_rx       = quad ? {rx[3:0], io_s2} : {rx[6:0], io_s2[0]};
    wire logic [2:0] next_bit_cnt  = bit_cnt + step;
    wire logic [2:0] next_out_cnt  = out_cnt + step;
    wire logic       byte_done     = active & sclk_rise & (state != ST_DATA_OUT) & (next_bit_cnt == 3'h0);
    wire logic       op_done       = byte_done & (state == ST_OPCODE);
    wire logic       op_ok         = opcode_valid(next_rx, quad, settings.deep_pd);
    // The latch is kept apart from the stored status so that 01h can never alter it.
    wire logic [7:0] status_view   = (settings.status & ~LATCH_MASK) |
                                     (settings.write_enable_latch ? LATCH_MASK : 8'h00);
    // Only a release exactly on a byte boundary with the right byte count executes.
    wire logic       exec          = cs_rise & (state == ST_DATA_IN) & (bit_cnt == 3'h0)
                                     & count_ok(opcode, n_bytes);
    wire frs_state_t next_state    = !op_ok ? ST_IGNORE : (is_read(next_rx) ? ST_DATA_OUT : ST_DATA_IN);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state   <= ST_OPCODE;
            rx      <= 8'h00;
            bit_cnt <= 3'h0;
            opcode  <= 8'h00;
            n_bytes <= 3'h0;
            dbuf    <= 32'h0000_0000;
        end else if (!active) begin
            state   <= ST_OPCODE;
            bit_cnt <= 3'h0;
            n_bytes <= 3'h0;
        end else if (sclk_rise && state != ST_DATA_OUT) begin
            rx      <= next_rx;
            bit_cnt <= next_bit_cnt;
            if (op_done) begin
                opcode <= next_rx;
                state  <= next_state;
            end else if (byte_done && state == ST_DATA_IN) begin
                dbuf    <= {dbuf[23:0], next_rx};
                n_bytes <= (n_bytes == 3'h7) ? n_bytes : n_bytes + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // Command execution
    // ----------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            settings    <= '{1'h0, 1'h0, 1'h0, 1'h0, STATUS_RST, CONFIG_RST, WRAP_RST, BOOT_ERASED};
            suspend_req <= 1'h0;
            resume_req  <= 1'h0;
        end else begin
            suspend_req <= exec && opcode == OP_SUSPEND;
            resume_req  <= exec && opcode == OP_RESUME;
            if (exec) begin
                case (opcode)
                    OP_SET_LATCH:    settings.write_enable_latch <= 1'h1;
                    OP_CLEAR_LATCH:  settings.write_enable_latch <= 1'h0;
                    OP_WRITE_STATUS: begin
                        if (n_bytes == 3'h1) begin
                            settings.status <= dbuf[7:0];
                        end else begin
                            settings.status <= dbuf[15:8];
                            settings.config_reg <= dbuf[7:0];
                        end
                    end
                    OP_PROTECT_SEL:  settings.block_protect <= 1'h1;
                    OP_ENTER_FOUR:   settings.four_wire <= 1'h1;
                    OP_EXIT_FOUR:    settings.four_wire <= 1'h0;
                    OP_PD_ENTER:     settings.deep_pd <= 1'h1;
                    OP_PD_RELEASE:   settings.deep_pd <= 1'h0;
                    OP_SET_WRAP:     settings.wrap_length <= dbuf[7:0];
                    OP_WRITE_BOOT:   settings.boot <= dbuf;
                    OP_ERASE_BOOT:   settings.boot <= BOOT_ERASED;
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Read data output
    // ----------------------------------------
    // Data changes on falling link edges so the host samples it stable on rising ones.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            io_drive <= '{4'h0, OE_N_OFF};
            out_sh   <= 8'h00;
            out_cnt  <= 3'h0;
            out_idx  <= 2'h0;
        end else if (!active) begin
            io_drive <= '{4'h0, OE_N_OFF};
        end else if (op_done && next_state == ST_DATA_OUT) begin
            out_sh  <= read_byte(next_rx, 2'h0, status_view, settings);
            out_cnt <= 3'h0;
            out_idx <= 2'h1;
        end else if (state == ST_DATA_OUT && sclk_fall) begin
            io_drive.out  <= quad ? out_sh[7:4] : {2'h0, out_sh[7], 1'h0};
            io_drive.oe_n <= quad ? OE_N_QUAD : OE_N_SINGLE;
            out_cnt       <= next_out_cnt;
            if (next_out_cnt == 3'h0) begin
                out_sh  <= read_byte(opcode, out_idx, status_view, settings);
                out_idx <= out_idx + 2'h1;
            end else begin
                out_sh <= quad ? {out_sh[3:0], 4'h0} : {out_sh[6:0], 1'h0};
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_latch_set_cmd: assert property (exec && opcode == OP_SET_LATCH |=> settings.write_enable_latch)
        else $error("write enable latch not set");
    a_latch_clear_cmd: assert property (exec && opcode == OP_CLEAR_LATCH |=> !settings.write_enable_latch)
        else $error("write enable latch not cleared");
    a_status_out_load: assert property (op_done && op_ok && next_rx == OP_READ_STATUS
        |=> state == ST_DATA_OUT && out_sh == $past(status_view)) else $error("status byte not loaded");
    a_config_out_load: assert property (op_done && op_ok && next_rx == OP_READ_CONFIG
        |=> state == ST_DATA_OUT && out_sh == $past(settings.config_reg)) else $error("config byte not loaded");
    a_status_pair_write: assert property (exec && opcode == OP_WRITE_STATUS && n_bytes == 3'h2
        |=> settings.status == $past(dbuf[15:8]) && settings.config_reg == $past(dbuf[7:0]))
        else $error("status and config not written");
    a_protect_select: assert property (exec && opcode == OP_PROTECT_SEL |=> settings.block_protect)
        else $error("block protect mode not selected");
    a_four_wire_mode: assert property (exec && (opcode == OP_ENTER_FOUR || opcode == OP_EXIT_FOUR)
        |=> settings.four_wire == ($past(opcode) == OP_ENTER_FOUR)) else $error("command mode wrong");
    a_suspend_pulse: assert property (exec && opcode == OP_SUSPEND |=> suspend_req ##1 !suspend_req)
        else $error("suspend pulse wrong");
    a_resume_pulse: assert property (exec && opcode == OP_RESUME |=> resume_req ##1 !resume_req)
        else $error("resume pulse wrong");
    a_power_down: assert property (exec && opcode == OP_PD_ENTER |=> settings.deep_pd)
        else $error("deep power-down not entered");
    a_power_release: assert property (exec && opcode == OP_PD_RELEASE |=> !settings.deep_pd)
        else $error("deep power-down not left");
    a_wrap_length: assert property (exec && opcode == OP_SET_WRAP
        |=> settings.wrap_length == $past(dbuf[7:0])) else $error("burst length not set");
    a_boot_quad_ignore: assert property (op_done && quad && next_rx == OP_READ_BOOT
        |=> state == ST_IGNORE) else $error("boot read accepted in four-wire mode");
    a_boot_write: assert property (exec && opcode == OP_WRITE_BOOT |=> settings.boot == $past(dbuf))
        else $error("boot register not written");
    a_partial_byte: assert property (cs_rise && bit_cnt != 3'h0 |=> $stable(settings) && !suspend_req)
        else $error("partial byte command executed");
    a_quad_keeps_status: assert property ($rose(settings.four_wire) |-> $stable(settings.status))
        else $error("status changed on four-wire entry");
    a_read_release: assert property (!active |=> io_drive.oe_n == OE_N_OFF)
        else $error("data lines driven with chip select high");
    a_invalid_ignored: assert property (op_done && !op_ok |=> state == ST_IGNORE ##1 !exec)
        else $error("invalid opcode not ignored");
    a_status_single: assert property (exec && opcode == OP_WRITE_STATUS && n_bytes == 3'h1
        |=> settings.status == $past(dbuf[7:0]) && $stable(settings.config_reg))
        else $error("single status byte not written");
    a_boot_erase: assert property (exec && opcode == OP_ERASE_BOOT |=> settings.boot == BOOT_ERASED)
        else $error("boot register not erased");
    a_power_down_deaf: assert property (op_done && settings.deep_pd && next_rx != OP_PD_RELEASE
        |=> state == ST_IGNORE) else $error("command heard in deep power-down");
    // Lane checks look one cycle after the falling link edge, where the registered output has just moved.
    a_quad_lanes: assert property (state == ST_DATA_OUT && quad && sclk_fall && active
        |=> io_drive.oe_n == OE_N_QUAD) else $error("four-wire read not on all lines");
    a_single_lane: assert property (state == ST_DATA_OUT && !quad && sclk_fall && active
        |=> io_drive.oe_n == OE_N_SINGLE && io_drive.out[1] == $past(out_sh[7]))
        else $error("single-wire read bit wrong");

    c_status_read: cover property (state == ST_DATA_OUT && opcode == OP_READ_STATUS && sclk_fall);
    c_status_write: cover property (exec && opcode == OP_WRITE_STATUS && n_bytes == 3'h2);
    c_enter_four: cover property (exec && opcode == OP_ENTER_FOUR);
    c_boot_write: cover property (exec && opcode == OP_WRITE_BOOT);
    c_quad_read: cover property (state == ST_DATA_OUT && quad && sclk_fall);

endmodule : frs_cmd_decoder

`default_nettype wire

// *** include/frs_pkg.sv ***
// Purpose: Shared constants and types for the flash register and setting command decoder.
// Assumes: Opcodes are one byte, shifted most significant bit first.
// Notes:   Reset values of the stored registers are plain defaults.
`default_nettype none

package frs_pkg;

    // ----------------------------------------
    // Opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_READ_STATUS  = 8'h05;
    localparam logic [7:0] OP_READ_CONFIG  = 8'h15;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PROTECT_SEL  = 8'h68;
    localparam logic [7:0] OP_ENTER_FOUR   = 8'h35;
    localparam logic [7:0] OP_EXIT_FOUR    = 8'hf5;
    localparam logic [7:0] OP_SUSPEND      = 8'hb0;
    localparam logic [7:0] OP_RESUME       = 8'h30;
    localparam logic [7:0] OP_PD_ENTER     = 8'hb9;
    localparam logic [7:0] OP_PD_RELEASE   = 8'hab;
    localparam logic [7:0] OP_SET_WRAP     = 8'hc0;
    localparam logic [7:0] OP_READ_BOOT    = 8'h16;
    localparam logic [7:0] OP_WRITE_BOOT   = 8'h17;
    localparam logic [7:0] OP_ERASE_BOOT   = 8'h18;

    // ----------------------------------------
    // Fields, counts and reset values
    // ----------------------------------------
    localparam logic [7:0]  LATCH_MASK    = 8'h02;
    localparam logic [2:0]  BOOT_BYTES    = 3'h4;
    localparam logic [7:0]  STATUS_RST    = 8'h00;
    localparam logic [7:0]  CONFIG_RST    = 8'h00;
    localparam logic [7:0]  WRAP_RST      = 8'h00;
    localparam logic [31:0] BOOT_ERASED   = 32'hffff_ffff;
    localparam logic [3:0]  OE_N_OFF      = 4'hf;
    localparam logic [3:0]  OE_N_SINGLE   = 4'hd;
    localparam logic [3:0]  OE_N_QUAD     = 4'h0;

    typedef enum logic [1:0] {
        ST_OPCODE   = 2'b00,
        ST_DATA_IN  = 2'b01,
        ST_DATA_OUT = 2'b10,
        ST_IGNORE   = 2'b11
    } frs_state_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe_n;
    } frs_pin_t;

    typedef struct packed {
        logic        write_enable_latch;
        logic        block_protect;
        logic        four_wire;
        logic        deep_pd;
        logic [7:0]  status;
        logic [7:0]  config_reg;
        logic [7:0]  wrap_length;
        logic [31:0] boot;
    } frs_settings_t;

endpackage : frs_pkg

`default_nettype wire

// *** bench/frs_host_model.sv ***
// Purpose: Host controller model that frames commands for the decoder over the serial link.
// Assumes: Serial mode 0; each link clock period is ten mclk cycles, five low and five high.
// Notes:   Lines the host is not driving toggle; undriven device lines read as their pull-up level, so a stale value is never taken for read data.
`default_nettype none

module frs_host_model (
    input  wire logic              mclk,
    input  wire frs_pkg::frs_pin_t io_drive,
    output logic                   cs_n,
    output logic                   sclk,
    output logic [3:0]             io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import frs_pkg::*;

    initial begin
        cs_n  = 1'b1;
        sclk  = 1'b0;
        io_in = 4'h0;
    end

    // ----------------------------------------
    // Link clock period
    // ----------------------------------------
    task automatic tick(input logic drive, input logic [3:0] val, output logic [3:0] seen);
        @(negedge mclk);
        sclk  = 1'b0;
        io_in = drive ? val : ~io_in;
        repeat (5) @(negedge mclk);
        // Lines the device leaves undriven read as their pull-up level, never a stale value.
        seen = io_drive.out | io_drive.oe_n;
        sclk = 1'b1;
        repeat (4) @(negedge mclk);
    endtask : tick

    // ----------------------------------------
    // One frame: nb whole bytes, xb stray edges, nr read edges
    // ----------------------------------------
    task automatic frame(input logic quad, input int nb, input logic [39:0] d, input int xb, input int nr,
                         output logic [31:0] rd, output logic [3:0] oe);
        logic [3:0]  seen;
        logic [39:0] sh;
        int          per;
        per = quad ? 2 : 8;
        sh  = d;
        rd  = 32'h0;
        oe  = OE_N_OFF;
        @(negedge mclk);
        cs_n = 1'b0;
        for (int i = 0; i < nb * per + xb; i++) begin
            tick(1'b1, quad ? sh[39:36] : {~io_in[3:1], sh[39]}, seen);
            sh = quad ? sh << 4 : sh << 1;
        end
        for (int i = 0; i < nr; i++) begin
            tick(1'b0, 4'h0, seen);
            rd = quad ? {rd[27:0], seen} : {rd[30:0], seen[1]};
            oe = io_drive.oe_n;
        end
        @(negedge mclk);
        sclk = 1'b0;
        repeat (2) @(negedge mclk);
        cs_n = 1'b1;
        repeat (8) @(negedge mclk);
    endtask : frame

endmodule : frs_host_model

`default_nettype wire

// *** bench/test_flash_register_setting_cmd_decoder.sv ***
// Purpose: Self-checking bench for the register and setting command decoder.
// Assumes: Commands act at chip select release and settle within eight mclk cycles.
// Notes:   Pulse outputs are counted on every rising mclk edge so a single-cycle pulse is never missed.
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end

module test_flash_register_setting_cmd_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import frs_pkg::*;

    logic          mclk;
    logic          resetn;
    logic          cs_n;
    logic          sclk;
    logic [3:0]    io_in;
    frs_pin_t      io;
    frs_settings_t st;
    logic          suspend_req;
    logic          resume_req;
    logic [31:0]   rd;
    logic [3:0]    oe;
    int            failures;
    int            cmp_count;
    int            cycles;
    int            n_susp;
    int            n_res;

    frs_cmd_decoder dut_u (
        .mclk        (mclk),
        .resetn      (resetn),
        .cs_n        (cs_n),
        .sclk        (sclk),
        .io_in       (io_in),
        .io_drive    (io),
        .settings    (st),
        .suspend_req (suspend_req),
        .resume_req  (resume_req)
    );

    frs_host_model host_u (
        .mclk     (mclk),
        .io_drive (io),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .io_in    (io_in)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ----------------------------------------
    // Pulse counters and watchdog
    // ----------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (suspend_req === 1'b1) n_susp++;
        if (resume_req === 1'b1) n_res++;
        if (cycles == 20000) begin
            failures++;
            finish_test;
        end
    end

    task automatic cmd(input logic q, input int nb, input logic [39:0] d);
        host_u.frame(q, nb, d, 0, 0, rd, oe);
    endtask : cmd

    task automatic rdc(input logic q, input logic [7:0] op, input int n);
        host_u.frame(q, 1, {op, 32'h0}, 0, n, rd, oe);
    endtask : rdc

    task automatic finish_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK(st.boot, BOOT_ERASED)
        `CHK(io.oe_n, OE_N_OFF)
        cmd(1'b0, 1, {OP_SET_LATCH, 32'h0});
        `CHK(st.write_enable_latch, 1'b1)
        rdc(1'b0, OP_READ_STATUS, 16);
        `CHK(rd[15:0], {2{STATUS_RST | LATCH_MASK}})
        `CHK(oe, OE_N_SINGLE)
        cmd(1'b0, 1, {OP_CLEAR_LATCH, 32'h0});
        `CHK(st.write_enable_latch, 1'b0)
        cmd(1'b0, 2, {OP_WRITE_STATUS, 8'h5c, 24'h0});
        `CHK({st.status, st.config_reg}, {8'h5c, CONFIG_RST})
        cmd(1'b0, 3, {OP_WRITE_STATUS, 8'ha4, 8'h3c, 16'h0});
        `CHK({st.status, st.config_reg}, 16'ha43c)
        cmd(1'b0, 4, {OP_WRITE_STATUS, 8'h11, 8'h22, 8'h33, 8'h00});
        `CHK({st.status, st.config_reg}, 16'ha43c)
        rdc(1'b0, OP_READ_CONFIG, 8);
        `CHK(rd[7:0], 8'h3c)
        rdc(1'b0, OP_READ_STATUS, 3);
        `CHK(rd[2:0], 3'h5)
        `CHK(io.oe_n, OE_N_OFF)
        host_u.frame(1'b0, 1, {OP_SET_LATCH, 32'h0}, 3, 0, rd, oe);
        `CHK(st.write_enable_latch, 1'b0)
        cmd(1'b0, 2, {OP_SET_WRAP, 8'h07, 24'h0});
        `CHK(st.wrap_length, 8'h07)
        cmd(1'b0, 1, {OP_PROTECT_SEL, 32'h0});
        `CHK(st.block_protect, 1'b1)
        cmd(1'b0, 1, {OP_SUSPEND, 32'h0});
        `CHK({n_susp, n_res}, {32'd1, 32'd0})
        cmd(1'b0, 1, {OP_RESUME, 32'h0});
        `CHK({n_susp, n_res}, {32'd1, 32'd1})
        cmd(1'b0, 1, {OP_PD_ENTER, 32'h0});
        `CHK(st.deep_pd, 1'b1)
        cmd(1'b0, 1, {OP_SET_LATCH, 32'h0});
        `CHK(st.write_enable_latch, 1'b0)
        cmd(1'b0, 1, {OP_PD_RELEASE, 32'h0});
        `CHK(st.deep_pd, 1'b0)
        cmd(1'b0, 5, {OP_WRITE_BOOT, 32'h1234_5678});
        `CHK(st.boot, 32'h1234_5678)
        rdc(1'b0, OP_READ_BOOT, 32);
        `CHK(rd, 32'h1234_5678)
        rdc(1'b0, OP_READ_BOOT, 8);
        `CHK(rd[7:0], 8'h12)
        rdc(1'b0, OP_READ_BOOT, 40);
        `CHK(rd, 32'h3456_7812)
        cmd(1'b0, 1, {OP_ERASE_BOOT, 32'h0});
        `CHK(st.boot, BOOT_ERASED)
        cmd(1'b0, 1, {OP_EXIT_FOUR, 32'h0});
        `CHK(st.four_wire, 1'b0)
        cmd(1'b0, 1, {OP_ENTER_FOUR, 32'h0});
        `CHK({st.four_wire, st.status}, {1'b1, 8'ha4})
        cmd(1'b1, 5, {OP_WRITE_BOOT, 32'h1234_5678});
        `CHK(st.boot, BOOT_ERASED)
        rdc(1'b1, OP_READ_BOOT, 4);
        `CHK({rd[15:0], oe}, {16'hffff, OE_N_OFF})
        cmd(1'b1, 1, {OP_SET_LATCH, 32'h0});
        `CHK(st.write_enable_latch, 1'b1)
        rdc(1'b1, OP_READ_STATUS, 4);
        `CHK(rd[15:0], 16'ha6a6)
        `CHK(oe, OE_N_QUAD)
        cmd(1'b1, 1, {OP_EXIT_FOUR, 32'h0});
        `CHK(st.four_wire, 1'b0)
        resetn = 1'b0;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK({st.status, st.config_reg, st.block_protect, st.write_enable_latch}, {STATUS_RST, CONFIG_RST, 2'h0})
        cmd(1'b0, 1, {OP_SET_LATCH, 32'h0});
        `CHK(st.write_enable_latch, 1'b1)
        finish_test;
    end

endmodule : test_flash_register_setting_cmd_decoder

`default_nettype wire
